// ===== inc/swu_pkg.sv
// What this block does
// - A stream in interactive mode has no length limit; it runs while software keeps reloading.
// - Moving a nibble into the shift register raises the empty interrupt and jump flag.
// - A nibble rewritten before the current one is out follows it without a restart.
// - A write of the holding register clears the empty interrupt and the jump flag, unless a load sets them in the same cycle.
// - After the last nibble the interrupt stays up until the next holding write; all is shifted out, then start clears itself.
// - Clearing the start bit during shifting aborts the transfer at once.
// - Two select bits give 1024, 2048, 8192 or 16384 Hz, slowest after reset.
// - Data changes on the rising clock edge so the receiver samples on the falling one.
// - When serial is active, port pin 0 is the clock and pin 1 the data.
// - Serial is active only with its enable set and the port set to output.
`default_nettype none

package swu_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and bit rates
   localparam int SYS_CLK_HZ = 200_000_000;
   localparam int RATE_00_HZ = 1024;
   localparam int RATE_01_HZ = 2048;
   localparam int RATE_10_HZ = 8192;
   localparam int RATE_11_HZ = 16384;
   // Half bit period in system cycles, rounded down
   localparam int HALF_00    = SYS_CLK_HZ / (2 * RATE_00_HZ);
   localparam int HALF_01    = SYS_CLK_HZ / (2 * RATE_01_HZ);
   localparam int HALF_10    = SYS_CLK_HZ / (2 * RATE_10_HZ);
   localparam int HALF_11    = SYS_CLK_HZ / (2 * RATE_11_HZ);
   localparam int CNT_W      = 17;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_HIGH     = 8'h04;
   localparam logic [7:0] OFS_HOLD     = 8'h08;
   localparam logic [7:0] OFS_FLAGS    = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_PORTD    = 8'h18;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_SEL_LSB  = 0;
   localparam int CTRL_OUT_EN   = 3;
   localparam int HIGH_START    = 2;
   localparam int FLG_JUMP      = 0;
   localparam int FLG_EMPTY_IRQ = 1;
   localparam int FLG_BUSY      = 2;
   localparam int FLG_HOLD_FULL = 3;
   localparam int EV_LOAD       = 0;
   localparam int EV_DONE       = 1;
   localparam int EV_ABORT      = 2;
   localparam int EV_W          = 3;
   localparam int PORTD_DIR     = 4;
   localparam int PORTD_PIN_LSB = 8;
   localparam int PD_SCK        = 0;
   localparam int PD_SDA        = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [1:0] RST_RATE_SEL = 2'h0;
   localparam logic [3:0] RST_HOLD     = 4'hF;
   localparam logic [3:0] RST_PORTD    = 4'h0;
   localparam logic [2:0] RST_EV_MASK  = 3'h0;

   typedef enum logic [2:0] {
      SWU_ST_IDLE = 3'b001,
      SWU_ST_HIGH = 3'b010,
      SWU_ST_LOW  = 3'b100
   } swu_state_t;

endpackage : swu_pkg

`default_nettype wire

// ===== verilog/swu_rate_gen.sv
`default_nettype none

module swu_rate_gen #(
   parameter int CNT_W = 17
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   // Control
   input  wire logic             run_i,
   input  wire logic [CNT_W-1:0] half_i,
   // Half period tick
   output logic                  tick_o
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } swu_gen_t;

   swu_gen_t r_reg;
   swu_gen_t r_next;

   assign tick_o = run_i && (r_reg.cnt >= (half_i - CNT_W'(1)));

   always_comb begin
      r_next = r_reg;
      // Restart from zero so the first edge of a nibble has a full half period
      if (!run_i || tick_o) begin
         r_next.cnt = '0;
      end else begin
         r_next.cnt = r_reg.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule : swu_rate_gen

`default_nettype wire

// ===== verilog/swu_top.sv
`default_nettype none

module swu_top #(
   parameter int CNT_W       = swu_pkg::CNT_W,
   parameter int HALF_CNT_00 = swu_pkg::HALF_00,
   parameter int HALF_CNT_01 = swu_pkg::HALF_01,
   parameter int HALF_CNT_10 = swu_pkg::HALF_10,
   parameter int HALF_CNT_11 = swu_pkg::HALF_11
) (
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        ARST_N_I,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Port pins
   input  wire logic [3:0]  PD_I,
   output logic      [3:0]  PD_O,
   output logic      [3:0]  PD_OE_N_O,
   // Interrupt
   output logic             IRQ_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      swu_pkg::swu_state_t      st;
      logic [1:0]               rate_sel;
      logic                     out_en;
      logic                     start;
      logic [3:0]               hold;
      logic                     hold_full;
      logic [3:0]               shift;
      logic [1:0]               idx;
      logic                     more;
      logic                     jump_flag;
      logic [swu_pkg::EV_W-1:0] ev_stat;
      logic [swu_pkg::EV_W-1:0] ev_mask;
      logic [3:0]               pd_data;
      logic                     pd_dir_out;
      logic [3:0]               pin_s1;
      logic [3:0]               pin_s2;
      logic                     sck;
      logic                     sda;
      logic [3:0]               pd_o;
      logic [3:0]               pd_oe_n;
      logic                     irq;
      logic                     ack;
      logic [31:0]              dat;
   } swu_regs_t;

   localparam swu_regs_t RST_REGS = '{
      st:         swu_pkg::SWU_ST_IDLE,
      rate_sel:   swu_pkg::RST_RATE_SEL,
      out_en:     1'b0,
      start:      1'b0,
      hold:       swu_pkg::RST_HOLD,
      hold_full:  1'b0,
      shift:      4'h0,
      idx:        2'h0,
      more:       1'b0,
      jump_flag:  1'b0,
      ev_stat:    3'h0,
      ev_mask:    swu_pkg::RST_EV_MASK,
      pd_data:    swu_pkg::RST_PORTD,
      pd_dir_out: 1'b0,
      pin_s1:     4'h0,
      pin_s2:     4'h0,
      sck:        1'b0,
      sda:        1'b0,
      pd_o:       4'h0,
      pd_oe_n:    4'hF,
      irq:        1'b0,
      ack:        1'b0,
      dat:        32'h0
   };

   swu_regs_t        r_reg;
   swu_regs_t        r_next;
   logic             tick;
   logic [CNT_W-1:0] half_cnt;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction : hit

   always_comb begin
      case (r_reg.rate_sel)
         2'h0:    half_cnt = CNT_W'(HALF_CNT_00);
         2'h1:    half_cnt = CNT_W'(HALF_CNT_01);
         2'h2:    half_cnt = CNT_W'(HALF_CNT_10);
         default: half_cnt = CNT_W'(HALF_CNT_11);
      endcase
   end

   swu_rate_gen #(
      .CNT_W    (CNT_W)
   ) i_swu_rate_gen (
      .clk_i    (SYS_CLK_I),
      .arst_n_i (ARST_N_I),
      .run_i    (r_reg.st != swu_pkg::SWU_ST_IDLE),
      .half_i   (half_cnt),
      .tick_o   (tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic                     acc;
      logic                     wr;
      logic                     active;
      logic                     load;
      logic [swu_pkg::EV_W-1:0] ev_set;
      logic [swu_pkg::EV_W-1:0] ev_clr;
      logic [31:0]              rd;
      acc    = 1'b0;
      wr     = 1'b0;
      active = 1'b0;
      load   = 1'b0;
      ev_set = '0;
      ev_clr = '0;
      rd     = 32'h0;
      r_next = r_reg;

      // Single cycle ack; write and read-clear happen on the ack edge
      acc          = WB_CYC_I && WB_STB_I && r_reg.ack;
      wr           = acc && WB_WE_I && WB_SEL_I[0];
      r_next.ack   = WB_CYC_I && WB_STB_I && !r_reg.ack;

      // Pins only reach logic through the second stage
      r_next.pin_s1 = PD_I;
      r_next.pin_s2 = r_reg.pin_s1;

      // Serial active only with enable and output mode
      active = r_reg.out_en && r_reg.pd_dir_out;

      case (r_reg.st)
         swu_pkg::SWU_ST_IDLE: begin
            r_next.sck = 1'b0;
            if (active && r_reg.start && r_reg.hold_full) begin
               load          = 1'b1;
               r_next.shift  = r_reg.hold;
               r_next.idx    = 2'h0;
               r_next.sck    = 1'b1;
               r_next.sda    = r_reg.hold[0];
               r_next.st     = swu_pkg::SWU_ST_HIGH;
            end
         end
         swu_pkg::SWU_ST_HIGH: begin
            if (!r_reg.start || !active) begin
               r_next.sck   = 1'b0;
               r_next.st    = swu_pkg::SWU_ST_IDLE;
               ev_set[swu_pkg::EV_ABORT] = 1'b1;
            end else if (tick) begin
               r_next.sck = 1'b0;
               r_next.st  = swu_pkg::SWU_ST_LOW;
               if (r_reg.idx != 2'h3) begin
                  r_next.more = 1'b1;
               end else if (r_reg.hold_full) begin
                  load         = 1'b1;
                  r_next.shift = r_reg.hold;
                  r_next.more  = 1'b1;
               end else begin
                  r_next.more = 1'b0;
               end
            end
         end
         swu_pkg::SWU_ST_LOW: begin
            if (!r_reg.start || !active) begin
               r_next.st = swu_pkg::SWU_ST_IDLE;
               ev_set[swu_pkg::EV_ABORT] = 1'b1;
            end else if (tick) begin
               if (r_reg.more) begin
                  // Next bit, LSB first, index wraps into new nibble
                  r_next.idx = r_reg.idx + 2'h1;
                  r_next.sda = r_reg.shift[r_next.idx];
                  // Data changes with the rising edge
                  r_next.sck = 1'b1;
                  r_next.st  = swu_pkg::SWU_ST_HIGH;
               end else begin
                  // All bits out, start clears itself
                  r_next.start = 1'b0;
                  r_next.st    = swu_pkg::SWU_ST_IDLE;
                  ev_set[swu_pkg::EV_DONE] = 1'b1;
               end
            end
         end
         default: begin
            r_next.sck = 1'b0;
            r_next.st  = swu_pkg::SWU_ST_IDLE;
         end
      endcase

      if (load) begin
         r_next.hold_full = 1'b0;
         r_next.jump_flag = 1'b1;
         ev_set[swu_pkg::EV_LOAD] = 1'b1;
      end

      // Register writes; a software write of start beats the self-clear
      if (wr) begin
         if (hit(WB_ADR_I, swu_pkg::OFS_CTRL)) begin
            r_next.rate_sel = WB_DAT_I[swu_pkg::CTRL_SEL_LSB +: 2];
            r_next.out_en   = WB_DAT_I[swu_pkg::CTRL_OUT_EN];
         end
         if (hit(WB_ADR_I, swu_pkg::OFS_HIGH)) begin
            r_next.start = WB_DAT_I[swu_pkg::HIGH_START];
         end
         if (hit(WB_ADR_I, swu_pkg::OFS_HOLD)) begin
            // Holding write clears interrupt and flag
            r_next.hold      = WB_DAT_I[3:0];
            r_next.hold_full = 1'b1;
            r_next.jump_flag = 1'b0;
         end
         if (hit(WB_ADR_I, swu_pkg::OFS_IRQ_MASK)) begin
            r_next.ev_mask = WB_DAT_I[swu_pkg::EV_W-1:0];
         end
         if (hit(WB_ADR_I, swu_pkg::OFS_PORTD)) begin
            r_next.pd_data    = WB_DAT_I[3:0];
            r_next.pd_dir_out = WB_DAT_I[swu_pkg::PORTD_DIR];
         end
      end

      // Hardware set wins over a same cycle clear
      if (load) begin
         r_next.jump_flag = 1'b1;
      end

      // Read clears only the bits that were returned
      if (acc && !WB_WE_I && hit(WB_ADR_I, swu_pkg::OFS_IRQ_STAT)) begin
         ev_clr = r_reg.dat[swu_pkg::EV_W-1:0];
      end
      r_next.ev_stat = (r_reg.ev_stat & ~ev_clr) | ev_set;

      // Read mux, unmapped reads give zero
      if (hit(WB_ADR_I, swu_pkg::OFS_CTRL)) begin
         rd[swu_pkg::CTRL_SEL_LSB +: 2] = r_reg.rate_sel;
         rd[swu_pkg::CTRL_OUT_EN]       = r_reg.out_en;
      end else if (hit(WB_ADR_I, swu_pkg::OFS_HIGH)) begin
         rd[swu_pkg::HIGH_START] = r_reg.start;
      end else if (hit(WB_ADR_I, swu_pkg::OFS_HOLD)) begin
         rd[3:0] = r_reg.hold;
      end else if (hit(WB_ADR_I, swu_pkg::OFS_FLAGS)) begin
         rd[swu_pkg::FLG_JUMP]      = r_reg.jump_flag;
         rd[swu_pkg::FLG_EMPTY_IRQ] = r_reg.jump_flag;
         rd[swu_pkg::FLG_BUSY]      = (r_reg.st != swu_pkg::SWU_ST_IDLE);
         rd[swu_pkg::FLG_HOLD_FULL] = r_reg.hold_full;
      end else if (hit(WB_ADR_I, swu_pkg::OFS_IRQ_STAT)) begin
         rd[swu_pkg::EV_W-1:0] = r_reg.ev_stat;
      end else if (hit(WB_ADR_I, swu_pkg::OFS_IRQ_MASK)) begin
         rd[swu_pkg::EV_W-1:0] = r_reg.ev_mask;
      end else if (hit(WB_ADR_I, swu_pkg::OFS_PORTD)) begin
         rd[3:0]                            = r_reg.pd_data;
         rd[swu_pkg::PORTD_DIR]             = r_reg.pd_dir_out;
         rd[swu_pkg::PORTD_PIN_LSB +: 4]    = r_reg.pin_s2;
      end
      r_next.dat = (r_next.ack && !WB_WE_I) ? rd : 32'h0;

      // Clock on pin 0, data on pin 1 when serial is active
      r_next.pd_o = r_next.pd_data;
      if (r_next.out_en && r_next.pd_dir_out) begin
         r_next.pd_o[swu_pkg::PD_SCK] = r_next.sck;
         r_next.pd_o[swu_pkg::PD_SDA] = r_next.sda;
      end
      // Plain port otherwise; whole port switches direction
      r_next.pd_oe_n = r_next.pd_dir_out ? 4'h0 : 4'hF;

      // Empty interrupt cannot be masked
      r_next.irq = r_next.jump_flag || (|(r_next.ev_stat & r_next.ev_mask));
   end

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         r_reg <= RST_REGS;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign WB_DAT_O  = r_reg.dat;
   assign WB_ACK_O  = r_reg.ack;
   assign PD_O      = r_reg.pd_o;
   assign PD_OE_N_O = r_reg.pd_oe_n;
   assign IRQ_O     = r_reg.irq;

endmodule : swu_top

`default_nettype wire

// ===== testbench/swu_top_monitor.sv
`default_nettype none

module swu_top_monitor #(
   parameter int CNT_W       = 17,
   parameter int HALF_CNT_00 = 8
) (
   // Clock and reset
   input wire logic        SYS_CLK_I,
   input wire logic        ARST_N_I,
   // Bus
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   // Pins
   input wire logic [3:0]  PD_I,
   input wire logic [3:0]  PD_O,
   input wire logic [3:0]  PD_OE_N_O,
   input wire logic        IRQ_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]       mask_reg;
   logic [CNT_W-1:0] low_reg;
   logic             wr_ack;
   assign wr_ack = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
   // Shadow mask, and length of the last low run of the serial clock
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mask_reg <= 3'h0;
         low_reg  <= '0;
      end else begin
         if (wr_ack && WB_ADR_I == swu_pkg::OFS_IRQ_MASK) begin
            mask_reg <= WB_DAT_I[2:0];
         end
         if (PD_O[0]) begin
            low_reg <= '0;
         end else if (low_reg != '1) begin
            low_reg <= low_reg + 1'b1;
         end
      end
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   ////////////////////////////////////////////////////////////////////////////////
   property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle"); // bus
   property p_ack_lat; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late"); // bus
   property p_dat_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data not zero"); // bus
   property p_oe_whole; PD_OE_N_O == 4'h0 || PD_OE_N_O == 4'hF; endproperty
   a_oe_whole: assert property (p_oe_whole) else $error("port enable split");
   property p_data_high; PD_O[0] && $past(PD_O[0]) |-> $stable(PD_O[1]); endproperty
   a_data_high: assert property (p_data_high) else $error("data moved in high");
   property p_hold_clr;
      wr_ack && WB_ADR_I == swu_pkg::OFS_HOLD && mask_reg == 3'h0 |-> ##[1:2] !IRQ_O;
   endproperty
   a_hold_clr: assert property (p_hold_clr) else $error("hold write kept irq");
   property p_abort;
      wr_ack && WB_ADR_I == swu_pkg::OFS_HIGH && !WB_DAT_I[swu_pkg::HIGH_START]
         |-> ##[1:3] !PD_O[0];
   endproperty
   a_abort: assert property (p_abort) else $error("clock ran after abort");
   property p_first_irq; $rose(PD_O[0]) && low_reg > HALF_CNT_00 + 1 |-> ##[0:1] IRQ_O;
   endproperty
   a_first_irq: assert property (p_first_irq) else $error("no irq at load");
   c_abort: cover property (wr_ack && WB_ADR_I == swu_pkg::OFS_HIGH && !WB_DAT_I[2]);
   c_run: cover property (PD_O[0] && IRQ_O);
   c_clr: cover property ($fell(IRQ_O));
endmodule : swu_top_monitor

bind swu_top swu_top_monitor #(.CNT_W(CNT_W), .HALF_CNT_00(HALF_CNT_00)) i_swu_top_monitor (
   .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PD_I(PD_I), .PD_O(PD_O),
   .PD_OE_N_O(PD_OE_N_O), .IRQ_O(IRQ_O));

`default_nettype wire

// ===== testbench/swu_rx_model.sv
`default_nettype none

module swu_rx_model (
   input  wire logic       clk_i,
   input  wire logic       sck_i,
   input  wire logic       sda_i,
   output logic      [3:0] nib_o,
   output int              cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] sh;
   logic       prev;
   int         nb;
   initial begin
      sh    = 4'h0;
      prev  = 1'b0;
      nb    = 0;
      nib_o = 4'h0;
      cnt_o = 0;
   end
   always @(posedge clk_i) begin
      if (prev === 1'b1 && sck_i === 1'b0) begin
         sh = {sda_i, sh[3:1]};
         nb++;
         // Outputs move by non-blocking update so the bench never races them
         if (nb == 4) begin
            nib_o <= sh;
            cnt_o <= cnt_o + 1;
            nb = 0;
         end
      end
      prev = sck_i;
   end
endmodule : swu_rx_model

`default_nettype wire

// ===== testbench/tb_serial_write_buffer_interactive.sv
`default_nettype none

module tb_serial_write_buffer_interactive;
   timeunit 1ns;
   timeprecision 1ps;
   // Half periods handed to the design below, code 0 in the low byte
   localparam logic [3:0][7:0] HALF = {8'h03, 8'h04, 8'h06, 8'h08};
   logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0, pd_in = 4'h9;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic        ack, irq, sck;
   logic [3:0]  pd_o, pd_oe_n, rx_nib;
   int          rx_cnt, n_mismatch = 0, tests_run = 0, hi, k, c0;
   assign sck = pd_o[0] & ~pd_oe_n[0];
   always #2.5 clk = ~clk;
   swu_top #(.HALF_CNT_00(8), .HALF_CNT_01(6), .HALF_CNT_10(4), .HALF_CNT_11(3)) i_swu_top (
      .SYS_CLK_I(clk), .ARST_N_I(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .PD_I(pd_in), .PD_O(pd_o), .PD_OE_N_O(pd_oe_n), .IRQ_O(irq));
   swu_rx_model i_swu_rx_model (.clk_i(clk), .sck_i(sck), .sda_i(pd_o[1]), .nib_o(rx_nib),
      .cnt_o(rx_cnt));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Classic cycle, held until ack is sampled; only the watchdog ends a hang
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'hF;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   task wait_on(input logic use_irq, input logic v);
      int n;
      n = 0;
      while ((use_irq ? irq : sck) !== v && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) chk(1'b0, 1'b1);
   endtask : wait_on
   task wait_idle;
      k = 0;
      do begin
         wb(1'b0, swu_pkg::OFS_HIGH, 32'h0);
         k++;
      end while (rd[swu_pkg::HIGH_START] !== 1'b0 && k < 500);
   endtask : wait_idle
   task final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      wb(1'b0, swu_pkg::OFS_CTRL, 32'h0); chk(rd, 32'h0);
      wb(1'b0, swu_pkg::OFS_FLAGS, 32'h0); chk(rd, 32'h0);
      wb(1'b1, 8'h1C, 32'hF); wb(1'b0, 8'h1C, 32'h0); chk(rd, 32'h0);
      wb(1'b1, swu_pkg::OFS_PORTD, 32'h1C);
      wb(1'b0, swu_pkg::OFS_PORTD, 32'h0);
      chk(rd, 32'h91C);
      chk(pd_oe_n, 4'h0);
      chk(pd_o, 4'hC);
      $display("test reset and port done");
      // Every rate code, one nibble each
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, swu_pkg::OFS_CTRL, 32'h8 | c);
         wb(1'b1, swu_pkg::OFS_HOLD, 32'h5 + c);
         wb(1'b1, swu_pkg::OFS_HIGH, 32'h4);
         wait_on(1'b1, 1'b1);
         wb(1'b0, swu_pkg::OFS_FLAGS, 32'h0); chk(rd, 32'h7);
         wait_on(1'b0, 1'b0);
         wait_on(1'b0, 1'b1);
         hi = 0;
         while (sck === 1'b1 && hi < 1000) begin
            @(posedge clk);
            hi++;
         end
         chk(hi, HALF[c]);
         wait_idle(); chk(rd, 32'h0);
         chk(rx_nib, 4'h5 + c); chk(irq, 1'b1);
         wb(1'b1, swu_pkg::OFS_HOLD, 32'h0);
         repeat (2) @(posedge clk);
         chk(irq, 1'b0);
      end
      wb(1'b0, swu_pkg::OFS_IRQ_STAT, 32'h0); chk(rd, 32'h3);
      wb(1'b0, swu_pkg::OFS_IRQ_STAT, 32'h0); chk(rd, 32'h0);
      $display("test rates done");
      // Three chained nibbles from one start
      c0 = rx_cnt;
      wb(1'b1, swu_pkg::OFS_CTRL, 32'h8);
      wb(1'b1, swu_pkg::OFS_HOLD, 32'hA);
      wb(1'b1, swu_pkg::OFS_HIGH, 32'h4);
      wait_on(1'b1, 1'b1);
      wb(1'b1, swu_pkg::OFS_HOLD, 32'h3);
      wait_on(1'b1, 1'b0); wait_on(1'b1, 1'b1);
      wb(1'b1, swu_pkg::OFS_HOLD, 32'hC);
      wait_on(1'b1, 1'b0); wait_on(1'b1, 1'b1);
      wait_idle();
      chk(rx_cnt - c0, 3); chk(rx_nib, 4'hC);
      wb(1'b1, swu_pkg::OFS_HOLD, 32'h0);
      $display("test chain done");
      // Abort in mid-nibble, events unmasked
      wb(1'b0, swu_pkg::OFS_IRQ_STAT, 32'h0);
      wb(1'b1, swu_pkg::OFS_IRQ_MASK, 32'h7);
      wb(1'b1, swu_pkg::OFS_HOLD, 32'h6);
      wb(1'b1, swu_pkg::OFS_HIGH, 32'h4);
      wait_on(1'b1, 1'b1);
      wait_on(1'b0, 1'b0);
      wb(1'b1, swu_pkg::OFS_HIGH, 32'h0);
      repeat (3) @(posedge clk);
      chk(sck, 1'b0);
      wb(1'b0, swu_pkg::OFS_FLAGS, 32'h0); chk(rd[swu_pkg::FLG_BUSY], 1'b0);
      wb(1'b1, swu_pkg::OFS_HOLD, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      wb(1'b0, swu_pkg::OFS_IRQ_STAT, 32'h0); chk(rd, 32'h5);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      $display("test abort done");
      final_report();
   end
endmodule : tb_serial_write_buffer_interactive

`default_nettype wire
